// File: hdl/gdfs_top.sv
// Fault supervision and power-state control for a three-phase gate driver
module gdfs_top
  import gdfs_pkg::*;
#(
  parameter int SLEEP_CYC = ns_up(1000000), // sleep delay
  parameter int WAKE_CYC = ns_up(1000000) // wake delay
) (
  input wire logic core_clk, // 50 MHz clock
  input wire logic nrst, // Async reset, active low
  input wire logic enable_pin, // Enable pin
  input wire logic supply_ok, // Supply above undervoltage
  input wire logic [2:0] high_side_pwm_in, // High-side PWM
  input wire logic [2:0] low_side_pwm_in, // Low-side PWM
  input wire logic [5:0] drain_source_overcurrent, // Per-MOSFET comparator
  input wire logic [7:0] shunt_sense_input, // Shunt sense sample
  input wire logic [5:0] gate_level_fb, // Gate voltage feedback
  input wire logic temp_warn_trip, // Above warning trip
  input wire logic temp_warn_hyst, // Still above warning hysteresis
  input wire logic temp_shut_trip, // Above shutdown trip
  input wire logic temp_shut_hyst, // Still above shutdown hysteresis
  output logic [2:0] high_side_gate_out, // High gate drive
  output logic [2:0] low_side_gate_out, // Low gate drive
  output logic gate_out_oe_n, // Gate drive enable, low drives
  output logic gate_weak_drive, // Reduced gate current
  output logic charge_pump_en, // Charge pump on
  output logic logic_regulator_en, // Logic regulator on
  output logic sense_amp_en, // Sense amps on
  output logic fault_indicator_n_o, // Fault pin output value
  output logic fault_indicator_n_oe, // Fault pin enable, low drives
  input wire logic s_axi_awvalid, // AXI write address
  output logic s_axi_awready, // AXI
  input wire logic [7:0] s_axi_awaddr, // AXI
  input wire logic s_axi_wvalid, // AXI write data
  output logic s_axi_wready, // AXI
  input wire logic [31:0] s_axi_wdata, // AXI
  input wire logic [3:0] s_axi_wstrb, // AXI
  output logic s_axi_bvalid, // AXI write response
  input wire logic s_axi_bready, // AXI
  output logic [1:0] s_axi_bresp, // AXI
  input wire logic s_axi_arvalid, // AXI read address
  output logic s_axi_arready, // AXI
  input wire logic [7:0] s_axi_araddr, // AXI
  output logic s_axi_rvalid, // AXI read data
  input wire logic s_axi_rready, // AXI
  output logic [31:0] s_axi_rdata, // AXI
  output logic [1:0] s_axi_rresp // AXI
);

  function automatic logic [CW-1:0] to_cw(input int v);
    return CW'(v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [23:0] sy1_r;
  logic [23:0] sy2_r;
  logic [7:0] sh1_r;
  logic [7:0] sh2_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sy1_r <= '0;
      sy2_r <= '0;
      sh1_r <= '0;
      sh2_r <= '0;
    end else begin
      sy1_r <= {enable_pin, supply_ok, high_side_pwm_in, low_side_pwm_in,
                drain_source_overcurrent, gate_level_fb, temp_warn_trip,
                temp_warn_hyst, temp_shut_trip, temp_shut_hyst};
      sy2_r <= sy1_r;
      sh1_r <= shunt_sense_input;
      sh2_r <= sh1_r;
    end
  end
  logic en_s, sup_s, tw_t, tw_h, ts_t, ts_h;
  logic [2:0] hin, lin;
  logic [5:0] ds_s, gfb;
  assign {en_s, sup_s, hin, lin, ds_s, gfb, tw_t, tw_h, ts_t, ts_h} = sy2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Power state and enable pulse timing
  gdfs_pwr_t pw_r;
  logic [CW-1:0] pcnt_r;
  logic [CW-1:0] lowcnt_r;
  logic en_d_r;
  logic rst_pulse;
  logic cfg_rst;
  logic clr_cmd;
  logic running;
  logic follow_ok;
  assign running = (pw_r == PW_RUN);
  // Short low phase on enable counts as a fault reset pulse
  assign rst_pulse = en_s && !en_d_r && lowcnt_r <= to_cw(RST_WIN_CYC);
  assign cfg_rst = (pw_r == PW_SLEEP) || !sup_s;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      en_d_r <= 1'b0;
      lowcnt_r <= '0;
    end else begin
      en_d_r <= en_s;
      if (en_s) lowcnt_r <= '0;
      else if (lowcnt_r != '1) lowcnt_r <= lowcnt_r + 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pw_r <= PW_SLEEP;
      pcnt_r <= '0;
    end else begin
      case (pw_r)
        PW_SLEEP: begin
          pcnt_r <= '0;
          if (en_s && sup_s) pw_r <= PW_WAKE;
        end
        PW_WAKE: begin
          pcnt_r <= pcnt_r + 1'b1;
          if (!en_s) begin
            pw_r <= PW_SLEEP;
          end else if (pcnt_r >= to_cw(WAKE_CYC - 1)) begin
            pw_r <= PW_RUN;
          end
        end
        PW_RUN: begin
          pcnt_r <= '0;
          if (!en_s || !sup_s) pw_r <= PW_DOWN;
        end
        PW_DOWN: begin
          pcnt_r <= pcnt_r + 1'b1;
          if (en_s && lowcnt_r == '0 && pcnt_r <= to_cw(RST_WIN_CYC + 1) && sup_s) begin
            pw_r <= PW_RUN;
            pcnt_r <= '0;
          end else if (pcnt_r >= to_cw(SLEEP_CYC - 1)) begin
            pw_r <= PW_SLEEP;
          end
        end
        default: pw_r <= PW_SLEEP;
      endcase
    end
  end
  assign follow_ok = running || (pw_r == PW_DOWN && pcnt_r < to_cw(FOLLOW_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // Registers over AXI4-Lite
  logic [31:0] ctrl_r;
  logic [31:0] time_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_r, w_r;
  logic [31:0] stat_v;
  logic [31:0] gate_v;
  logic [1:0] mode;
  logic hw_cfg;
  assign s_axi_awready = !aw_r && !s_axi_bvalid;
  assign s_axi_wready = !w_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign hw_cfg = ctrl_r[B_HWCFG];
  assign mode = hw_cfg ? MODE_RETRY : ctrl_r[B_MODE+:2];
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8+:8] = d[i*8+:8];
    end
    return r;
  endfunction
  logic wr_go;
  assign wr_go = aw_r && w_r && !s_axi_bvalid;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == A_CTRL || awaddr_r == A_TIME) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
      time_r <= TIME_RST;
    end else if (cfg_rst) begin
      ctrl_r <= CTRL_RST;
      time_r <= TIME_RST;
    end else begin
      ctrl_r[B_CLR] <= 1'b0;
      if (wr_go && awaddr_r == A_CTRL) ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
      if (wr_go && awaddr_r == A_TIME) time_r <= merge(time_r, wdata_r, wstrb_r);
    end
  end
  assign clr_cmd = ctrl_r[B_CLR] || rst_pulse;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        A_CTRL: s_axi_rdata <= ctrl_r;
        A_TIME: s_axi_rdata <= time_r;
        A_STAT: s_axi_rdata <= stat_v;
        A_GATE: s_axi_rdata <= gate_v;
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent detection and response
  logic [CW-1:0] deg_lim, drv_lim, retry_lim;
  logic [7:0] shunt_lvl;
  logic shunt_en;
  logic [CW-1:0] degcnt_r, retcnt_r;
  logic shunt_ev;
  logic [5:0] ds_flag_r;
  logic ds_oc_r, sh_oc_r;
  logic latched_off_r, retry_off_r, report_r;
  logic oc_now;
  assign deg_lim = hw_cfg ? to_cw(HW_DEG_CYC) : CW'(time_r[7:0] * US_CYC);
  assign drv_lim = CW'(time_r[15:8] * US_CYC);
  assign retry_lim = hw_cfg ? to_cw(HW_RETRY_CYC) : CW'(time_r[23:16] * MS_CYC);
  assign shunt_lvl = hw_cfg ? HW_SHUNT_LVL : ctrl_r[B_LVL+:8];
  assign shunt_en = mode != MODE_OFF && !ctrl_r[B_SOFF];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      degcnt_r <= '0;
    end else if (sh2_r > shunt_lvl && running) begin
      if (degcnt_r <= deg_lim) degcnt_r <= degcnt_r + 1'b1;
    end else begin
      degcnt_r <= '0;
    end
  end
  assign shunt_ev = shunt_en && degcnt_r == deg_lim + 1'b1 && running;
  logic ds_ev;
  assign ds_ev = running && |ds_s && mode != MODE_OFF;
  assign oc_now = |ds_s || sh2_r > shunt_lvl;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ds_flag_r <= '0;
      ds_oc_r <= 1'b0;
      sh_oc_r <= 1'b0;
      latched_off_r <= 1'b0;
      retry_off_r <= 1'b0;
      report_r <= 1'b0;
      retcnt_r <= '0;
    end else begin
      if (retry_off_r) begin
        retcnt_r <= retcnt_r + 1'b1;
        if (retcnt_r >= retry_lim) begin
          retry_off_r <= 1'b0;
          ds_oc_r <= 1'b0;
          sh_oc_r <= 1'b0;
          ds_flag_r <= '0;
        end
      end
      if (clr_cmd && !oc_now) begin
        latched_off_r <= 1'b0;
        report_r <= 1'b0;
        if (!retry_off_r) begin
          ds_oc_r <= 1'b0;
          sh_oc_r <= 1'b0;
          ds_flag_r <= '0;
        end
      end
      if (ds_ev || shunt_ev) begin
        ds_oc_r <= ds_oc_r | ds_ev;
        sh_oc_r <= sh_oc_r | shunt_ev;
        ds_flag_r <= ds_flag_r | (ds_ev ? ds_s : 6'h00);
        case (mode)
          MODE_LATCH: latched_off_r <= 1'b1;
          MODE_RETRY: begin
            retry_off_r <= 1'b1;
            retcnt_r <= '0;
          end
          MODE_REPORT: report_r <= 1'b1;
          default: report_r <= report_r;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate stuck detection
  logic [5:0] cmd_g;
  logic [5:0] gf_flag_r;
  logic [CW-1:0] gcnt_r [6];
  logic gdf_r;
  logic [5:0] stuck;
  assign cmd_g = {high_side_gate_out, low_side_gate_out};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 6; i++) gcnt_r[i] <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (cmd_g[i] == gfb[i] || gate_out_oe_n) gcnt_r[i] <= '0;
        else if (gcnt_r[i] <= drv_lim) gcnt_r[i] <= gcnt_r[i] + 1'b1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 6; i++) stuck[i] = gcnt_r[i] > drv_lim;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gdf_r <= 1'b0;
      gf_flag_r <= '0;
    end else if (ctrl_r[B_GOFF]) begin
      gdf_r <= 1'b0;
      gf_flag_r <= '0;
    end else if (|stuck) begin
      gdf_r <= 1'b1;
      gf_flag_r <= gf_flag_r | stuck;
    end else if (clr_cmd) begin
      gdf_r <= 1'b0;
      gf_flag_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal
  logic tw_r, ts_act_r, tsd_flag_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tw_r <= 1'b0;
      ts_act_r <= 1'b0;
      tsd_flag_r <= 1'b0;
    end else begin
      if (tw_t) tw_r <= 1'b1;
      else if (!tw_h) tw_r <= 1'b0;
      if (ts_t) ts_act_r <= 1'b1;
      else if (!ts_h) ts_act_r <= 1'b0;
      if (ts_t) tsd_flag_r <= 1'b1;
      else if (clr_cmd) tsd_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic gates_off;
  logic fault_any;
  logic pin_low;
  assign gates_off = latched_off_r || retry_off_r || gdf_r || ts_act_r;
  assign fault_any = ds_oc_r || sh_oc_r || gdf_r || tsd_flag_r || latched_off_r
                     || retry_off_r || report_r;
  assign pin_low = latched_off_r || retry_off_r || report_r || gdf_r || ts_act_r
                   || (tw_r && ctrl_r[B_WREP])
                   || pw_r == PW_WAKE || (pw_r == PW_DOWN && !follow_ok);
  assign stat_v = {9'h0, pw_r, tsd_flag_r, ts_act_r, tw_r, gdf_r, gf_flag_r,
                   sh_oc_r, ds_oc_r, ds_flag_r, fault_any};
  assign gate_v = {26'h0, gfb};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      high_side_gate_out <= '0;
      low_side_gate_out <= '0;
      gate_out_oe_n <= 1'b1;
      gate_weak_drive <= 1'b0;
      charge_pump_en <= 1'b0;
      logic_regulator_en <= 1'b0;
      sense_amp_en <= 1'b0;
      fault_indicator_n_oe <= 1'b1;
    end else begin
      if (follow_ok && !gates_off) begin
        high_side_gate_out <= hin;
        low_side_gate_out <= lin;
        gate_out_oe_n <= 1'b0;
      end else begin
        high_side_gate_out <= '0;
        low_side_gate_out <= '0;
        // Float only when a gate was still high at the end of following
        gate_out_oe_n <= gates_off ? 1'b0 : (|cmd_g || gate_out_oe_n);
      end
      gate_weak_drive <= retry_off_r || latched_off_r;
      charge_pump_en <= pw_r != PW_SLEEP && !ts_act_r;
      logic_regulator_en <= pw_r != PW_SLEEP;
      sense_amp_en <= running;
      fault_indicator_n_oe <= !pin_low;
    end
  end
  assign fault_indicator_n_o = 1'b0;
endmodule

// File: hdl/gdfs_pkg.sv
// Constants for the gate driver fault supervisor
// Function
// - Retry overcurrent: all MOSFETs off with weak drive, pin low, flags set.
// - Retry ends after retry interval: drive resumes, pin released, flags cleared.
// - Report-only: gates follow inputs, pin low, flags latched.
// - Report-only release needs condition gone and a clear or enable pulse.
// - Mode 11b ignores drain-source overcurrent.
// - Shunt event after deglitch; fixed variant: 1 V level, 4 ms retry.
// - Programmable variant: level, deglitch from settings; shared response mode.
// - Latched shunt event: MOSFETs off, pin low until condition gone and clear.
// - Shunt path off in mode 11b or by shunt-off bit only.
// - Gate not slewing in drive time: gate fault, MOSFETs off, pin low.
// - Gate fault needs condition gone and clear; gate-check-off disables it.
// - Warning flag follows trip and hysteresis, no other action.
// - Warning-to-pin bit also pulls the fault pin low.
// - Shutdown: MOSFETs and pump off, pin low; resumes when cool.
// - Trip flag held until clear; shutdown always enabled.
// - Enable low: sleep after delay, drivers, pump, regulator off; port still answers, writes have no effect.
// - Gates follow inputs 50 us after enable falls, then float if high.
// - Enable high wakes device; controller waits wake delay.
// - Fault pin low while regulators switch, no longer than delay.
// - Operating mode needs enable high and supply good.
// - Short enable low pulse clears latched faults; longer starts shutdown.
// - Config to defaults at power-up, sleep entry and undervoltage.
package gdfs_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int NS_PER_S = 1000000000;
  function automatic int ns_up(input int ns);
    return int'((64'(ns) * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  endfunction
  function automatic int ns_dn(input int ns);
    return int'((64'(ns) * CLK_HZ) / NS_PER_S);
  endfunction
  localparam int FOLLOW_NS = 50000;
  localparam int FOLLOW_CYC = ns_dn(FOLLOW_NS);
  localparam int FLOAT_MAX_NS = 400000;
  localparam int FLOAT_CYC = ns_dn(FLOAT_MAX_NS);
  localparam int RST_WIN_NS = 40000;
  localparam int RST_WIN_CYC = ns_dn(RST_WIN_NS);
  localparam int HW_RETRY_NS = 4000000;
  localparam int HW_RETRY_CYC = ns_up(HW_RETRY_NS);
  localparam int HW_DEG_NS = 4000;
  localparam int HW_DEG_CYC = ns_up(HW_DEG_NS);
  localparam logic [7:0] HW_SHUNT_LVL = 8'h64; // 1 V at 10 mV per code
  localparam int CW = 24;
  // Response mode codes
  localparam logic [1:0] MODE_LATCH = 2'h0;
  localparam logic [1:0] MODE_RETRY = 2'h1;
  localparam logic [1:0] MODE_REPORT = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TIME = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_GATE = 8'h0c;
  // Control register fields
  localparam int B_MODE = 0;
  localparam int B_SOFF = 2;
  localparam int B_GOFF = 3;
  localparam int B_WREP = 4;
  localparam int B_CLR = 5;
  localparam int B_HWCFG = 6;
  localparam int B_LVL = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_6401;
  // Timing register: deglitch [7:0] x 1 us, drive time [15:8] x 1 us, retry [23:16] x 1 ms
  localparam logic [31:0] TIME_RST = 32'h0004_0404;
  localparam int US_CYC = ns_up(1000);
  localparam int MS_CYC = ns_up(1000000);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    PW_SLEEP = 4'h1,
    PW_WAKE = 4'h2,
    PW_RUN = 4'h4,
    PW_DOWN = 4'h8
  } gdfs_pwr_t;
endpackage

// File: bench/gdfs_props.sv
// Checker properties for the gate driver fault supervisor
module gdfs_props
  import gdfs_pkg::*;
#(
  parameter int SLEEP_CYC = 3000 // sleep delay in cycles
) (
  input wire logic core_clk, // clock
  input wire logic nrst, // reset
  input wire logic enable_pin, // enable
  input wire logic [2:0] high_side_gate_out, // high gates
  input wire logic [2:0] low_side_gate_out, // low gates
  input wire logic gate_weak_drive, // weak drive
  input wire logic charge_pump_en, // pump
  input wire logic logic_regulator_en, // regulator
  input wire logic sense_amp_en, // sense amps
  input wire logic fault_indicator_n_oe, // fault pin
  input wire logic temp_shut_trip // overheat
);
  localparam int FOLLOW_LIM = FOLLOW_CYC + 4;
  localparam int SLEEP_LIM = SLEEP_CYC + 8;
  logic [15:0] low_cnt_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // Cycles since enable fell, saturating
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt_r <= 16'h0000;
    end else if (enable_pin) begin
      low_cnt_r <= 16'h0000;
    end else if (low_cnt_r != 16'hffff) begin
      low_cnt_r <= low_cnt_r + 16'h0001;
    end
  end
  ////////////////////////////////////////
  weak_gates_off_a: assert property (
    gate_weak_drive |-> high_side_gate_out == 3'h0 && low_side_gate_out == 3'h0)
    else $error("gate driven during weak turn-off");
  weak_fault_low_a: assert property (
    gate_weak_drive |-> !fault_indicator_n_oe)
    else $error("fault pin released during weak turn-off");
  hot_stop_a: assert property (
    (enable_pin && temp_shut_trip)[*6] |-> !charge_pump_en && !fault_indicator_n_oe)
    else $error("overheat did not stop pump and pull fault pin");
  pump_off_gates_a: assert property (
    !charge_pump_en |-> high_side_gate_out == 3'h0 && low_side_gate_out == 3'h0)
    else $error("gates driven with pump off");
  follow_end_a: assert property (
    int'(low_cnt_r) > FOLLOW_LIM |-> high_side_gate_out == 3'h0 && low_side_gate_out == 3'h0)
    else $error("gates still follow inputs long after enable fell");
  sleep_off_a: assert property (
    int'(low_cnt_r) > SLEEP_LIM |-> !charge_pump_en && !logic_regulator_en && !sense_amp_en)
    else $error("supplies still on in sleep");
  sleep_pin_rel_a: assert property (
    int'(low_cnt_r) > SLEEP_LIM |-> fault_indicator_n_oe)
    else $error("fault pin held low past sleep delay");
  no_wake_low_a: assert property (
    int'(low_cnt_r) >= 8 |-> !$rose(logic_regulator_en))
    else $error("regulator started with enable low");
  cover property (gate_weak_drive);
  cover property (int'(low_cnt_r) > SLEEP_LIM);
  cover property (temp_shut_trip && !charge_pump_en);
endmodule
bind gdfs_top gdfs_props #(.SLEEP_CYC(SLEEP_CYC)) u_gdfs_props (
  .core_clk(core_clk), .nrst(nrst), .enable_pin(enable_pin),
  .high_side_gate_out(high_side_gate_out), .low_side_gate_out(low_side_gate_out),
  .gate_weak_drive(gate_weak_drive), .charge_pump_en(charge_pump_en),
  .logic_regulator_en(logic_regulator_en), .sense_amp_en(sense_amp_en),
  .fault_indicator_n_oe(fault_indicator_n_oe), .temp_shut_trip(temp_shut_trip)
);

// File: bench/gdfs_ctl_model.sv
// Motor controller model driving enable and PWM inputs
module gdfs_ctl_model #(
  parameter int DLY = 3000 // sleep and wake delay in cycles
) (
  input wire logic core_clk, // clock
  output logic enable_pin, // enable
  output logic [2:0] high_side_pwm_in, // high PWM
  output logic [2:0] low_side_pwm_in // low PWM
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    enable_pin = 1'b0;
    high_side_pwm_in = 3'h0;
    low_side_pwm_in = 3'h0;
  end
  task automatic drive(input logic [2:0] h, input logic [2:0] l);
    @(posedge core_clk);
    high_side_pwm_in <= h;
    low_side_pwm_in <= l;
  endtask
  task automatic power(input logic on);
    @(posedge core_clk);
    enable_pin <= on;
    if (!on) begin
      high_side_pwm_in <= 3'h0;
      low_side_pwm_in <= 3'h0;
    end
    repeat (DLY + 50) @(posedge core_clk);
  endtask
  task automatic pulse(input int n);
    @(posedge core_clk);
    enable_pin <= 1'b0;
    repeat (n) @(posedge core_clk);
    enable_pin <= 1'b1;
  endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the gate driver fault supervisor
module tb import gdfs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 3000;
  logic core_clk = 1'b0, nrst = 1'b0, supply_ok = 1'b1, enable_pin;
  logic [2:0] high_side_pwm_in, low_side_pwm_in, high_side_gate_out, low_side_gate_out;
  logic [5:0] drain_source_overcurrent = 6'h00, gate_level_fb = 6'h00;
  logic [7:0] shunt_sense_input = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic temp_warn_trip = 1'b0, temp_warn_hyst = 1'b0, temp_shut_trip = 1'b0;
  logic temp_shut_hyst = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic gate_weak_drive, charge_pump_en, logic_regulator_en, sense_amp_en;
  logic fault_indicator_n_oe, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int errors = 0, n_compared = 0;
  gdfs_top #(.SLEEP_CYC(DLY), .WAKE_CYC(DLY)) u_gdfs_top (
    .core_clk, .nrst, .enable_pin, .supply_ok, .high_side_pwm_in, .low_side_pwm_in,
    .drain_source_overcurrent, .shunt_sense_input, .gate_level_fb, .temp_warn_trip,
    .temp_warn_hyst, .temp_shut_trip, .temp_shut_hyst, .high_side_gate_out,
    .low_side_gate_out, .gate_out_oe_n(), .gate_weak_drive, .charge_pump_en,
    .logic_regulator_en, .sense_amp_en, .fault_indicator_n_o(), .fault_indicator_n_oe,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp
  );
  gdfs_ctl_model #(.DLY(DLY)) u_gdfs_ctl_model (
    .core_clk, .enable_pin, .high_side_pwm_in, .low_side_pwm_in
  );
  always #10 core_clk = ~core_clk;
  ////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rv & m, e);
  endtask
  task automatic pin(input logic e);
    chk({31'h0, fault_indicator_n_oe}, {31'h0, e});
  endtask
  // Apply fault conditions and let them outlast the deglitch and drive times
  task automatic cond(input logic [5:0] d, input logic [7:0] s, input logic [5:0] f);
    @(posedge core_clk);
    drain_source_overcurrent <= d;
    shunt_sense_input <= s;
    gate_level_fb <= f;
    wt(300);
  endtask
  task automatic results;
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #1_900_000;
    errors++;
    results();
  end
  initial begin
    wt(3);
    nrst <= 1'b1;
    wt(2);
    fork
      u_gdfs_ctl_model.power(1'b1);
      begin
        wt(20);
        pin(1'b0);
      end
    join
    pin(1'b1);
    chk({29'h0, charge_pump_en, logic_regulator_en, sense_amp_en}, 32'h7);
    rchk(A_STAT, 32'hffff_ffff, 32'h0020_0000);
    rchk(A_CTRL, 32'hffff_ffff, 32'h0000_6401);
    rchk(A_TIME, 32'hffff_ffff, 32'h0004_0404);
    rd(8'h10);
    chk({30'h0, rr}, 32'h2);
    chk(rv, 32'h0);
    wr(A_CTRL, 32'h0000_640a);
    u_gdfs_ctl_model.drive(3'h7, 3'h0);
    cond(6'h01, 8'h00, 6'h00);
    pin(1'b0);
    chk({29'h0, high_side_gate_out}, 32'h7);
    rchk(A_STAT, 32'hff, 32'h83);
    cond(6'h00, 8'h00, 6'h00);
    pin(1'b0);
    wr(A_CTRL, 32'h0000_642a);
    wt(5);
    pin(1'b1);
    rchk(A_STAT, 32'hff, 32'h0);
    cond(6'h01, 8'h00, 6'h00);
    cond(6'h00, 8'h00, 6'h00);
    u_gdfs_ctl_model.pulse(100);
    wt(20);
    pin(1'b1);
    rchk(A_STAT, 32'h0078_00ff, 32'h0020_0000);
    rchk(A_CTRL, 32'hffff_ffff, 32'h0000_640a);
    wr(A_CTRL, 32'h0000_640b);
    cond(6'h01, 8'h00, 6'h00);
    pin(1'b1);
    rchk(A_STAT, 32'hff, 32'h0);
    wr(A_CTRL, 32'h0000_640c);
    cond(6'h01, 8'h80, 6'h00);
    rchk(A_STAT, 32'h181, 32'h81);
    cond(6'h00, 8'h00, 6'h00);
    wr(A_CTRL, 32'h642c);
    wr(A_CTRL, 32'h6408);
    cond(6'h00, 8'h80, 6'h00);
    pin(1'b0);
    chk({29'h0, high_side_gate_out}, 32'h0);
    rchk(A_STAT, 32'h181, 32'h101);
    cond(6'h00, 8'h00, 6'h00);
    pin(1'b0);
    wr(A_CTRL, 32'h0000_6428);
    wt(5);
    pin(1'b1);
    chk({29'h0, high_side_gate_out}, 32'h7);
    u_gdfs_ctl_model.drive(3'h0, 3'h0);
    wr(A_CTRL, 32'h0000_6403);
    cond(6'h00, 8'h00, 6'h3f);
    pin(1'b0);
    rchk(A_STAT, 32'hfe01, 32'hfe01);
    cond(6'h00, 8'h00, 6'h00);
    pin(1'b0);
    wr(A_CTRL, 32'h0000_6423);
    wt(5);
    pin(1'b1);
    wr(A_CTRL, 32'h0000_640b);
    cond(6'h00, 8'h00, 6'h3f);
    pin(1'b1);
    cond(6'h00, 8'h00, 6'h00);
    temp_warn_trip <= 1'b1;
    temp_warn_hyst <= 1'b1;
    wt(10);
    pin(1'b1);
    rchk(A_STAT, 32'h1_0000, 32'h1_0000);
    wr(A_CTRL, 32'h0000_641b);
    wt(5);
    pin(1'b0);
    temp_warn_trip <= 1'b0;
    temp_warn_hyst <= 1'b0;
    wt(10);
    rchk(A_STAT, 32'h1_0000, 32'h0);
    pin(1'b1);
    temp_shut_trip <= 1'b1;
    temp_shut_hyst <= 1'b1;
    wt(10);
    chk({31'h0, charge_pump_en}, 32'h0);
    pin(1'b0);
    rchk(A_STAT, 32'h6_0000, 32'h6_0000);
    temp_shut_trip <= 1'b0;
    temp_shut_hyst <= 1'b0;
    wt(DLY + 50);
    chk({31'h0, charge_pump_en}, 32'h1);
    pin(1'b1);
    rchk(A_STAT, 32'h6_0000, 32'h4_0000);
    wr(A_CTRL, 32'h0000_643b);
    wt(5);
    rchk(A_STAT, 32'h4_0000, 32'h0);
    wr(A_TIME, 32'h0001_0404);
    wr(A_CTRL, 32'h0000_6409);
    u_gdfs_ctl_model.drive(3'h7, 3'h0);
    cond(6'h01, 8'h00, 6'h00);
    chk({28'h0, gate_weak_drive, high_side_gate_out}, 32'h8);
    pin(1'b0);
    rchk(A_STAT, 32'hff, 32'h83);
    cond(6'h00, 8'h00, 6'h00);
    wt(39500);
    pin(1'b0);
    rchk(A_STAT, 32'hff, 32'h83);
    wt(10300);
    pin(1'b1);
    rchk(A_STAT, 32'hff, 32'h0);
    chk({29'h0, high_side_gate_out}, 32'h7);
    u_gdfs_ctl_model.power(1'b0);
    chk({29'h0, charge_pump_en, logic_regulator_en, sense_amp_en}, 32'h0);
    pin(1'b1);
    u_gdfs_ctl_model.power(1'b1);
    rchk(A_CTRL, 32'hffff_ffff, 32'h0000_6401);
    rchk(A_TIME, 32'hffff_ffff, 32'h0004_0404);
    results();
  end
endmodule
